/* File: src/pbar_defs.svh */
// pbar_defs.svh: address map, reset values and rate constants of the peripheral bus path
// assumes: included by bare name from every design file of the block except the package
`ifndef PBAR_DEFS_SVH
`define PBAR_DEFS_SVH
`define PBAR_RAM_BASE    16'hfe00
`define PBAR_RAM_TOP     16'hfeff
`define PBAR_WIDE_ADDR   16'hffa0
`define PBAR_TMR_ADDR    16'hffb0
`define PBAR_PDAT_ADDR   16'hffd8
`define PBAR_PDIR_ADDR   16'hffe8
`define PBAR_PDAT_RST    8'h00
`define PBAR_PDIR_RST    8'h00
`define PBAR_TMR_RST     8'h00
`define PBAR_WIDE_RST    16'h0000
`define PBAR_DIR_READ    8'hff
`define PBAR_UNMAP_READ  16'hffff
`define PBAR_SUB_DIV     4'h7
`define PBAR_TWO_STATE   2'h2
`define PBAR_THREE_STATE 2'h3
`endif

/* File: src/pbar_pkg.sv */
// pbar_pkg.sv: types shared by the peripheral bus access path
// assumes: widths are fixed; constants live in pbar_defs.svh
package pbar_pkg;
   typedef enum logic [2:0] {
      op_read                        = 3'h0,
      op_write                       = 3'h1,
      bit_set_instruction            = 3'h2,
      bit_clear_instruction          = 3'h3,
      bit_invert_instruction         = 3'h4,
      bit_store_instruction          = 3'h5,
      bit_inverted_store_instruction = 3'h6,
      block_move_instruction         = 3'h7
   } pbar_op_t;
   typedef enum logic [2:0] {
      fsm_idle   = 3'h1,
      fsm_bus    = 3'h2,
      fsm_modify = 3'h4
   } pbar_fsm_t;
   typedef enum logic [6:0] {
      cpu_reset     = 7'h01,
      cpu_exception = 7'h02,
      cpu_active    = 7'h04,
      cpu_subactive = 7'h08,
      cpu_sleep     = 7'h10,
      cpu_standby   = 7'h20,
      cpu_subsleep  = 7'h40
   } pbar_cpu_t;
   typedef struct packed {
      pbar_fsm_t   fsm;
      pbar_cpu_t   cpu;
      logic [3:0]  div;
      logic [1:0]  st;
      pbar_op_t    op;
      logic        wr;
      logic        word;
      logic        half;
      logic [15:0] addr;
      logic [15:0] src;
      logic [15:0] dst;
      logic [7:0]  cnt;
      logic [15:0] wd;
      logic [15:0] rd;
      logic [2:0]  bitn;
      logic        bitv;
      logic        done;
      logic        err;
   } pbar_core_t;
   typedef struct packed {
      logic [7:0]  port_five_data_latch;
      logic [7:0]  port_five_direction;
      logic [7:0]  reload;
      logic [7:0]  count;
      logic [15:0] wide;
   } pbar_per_t;
endpackage

/* File: src/pbar_periph.sv */
// pbar_periph.sv: peripheral registers: port five, shared counter/reload, a 16-bit register
// assumes: one access strobe per completed write cycle, in its last state; reads are combinational
`timescale 1ns/1ns
`include "pbar_defs.svh"
module pbar_periph (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [15:0] acc_addr,
   input  wire logic [15:0] acc_wdata,
   input  wire logic        acc_wr,
   output logic      [15:0] acc_rdata,
   input  wire logic [7:0]  port_five_pin_in,
   output logic      [7:0]  port_five_pin_out,
   output logic      [7:0]  port_five_pin_oe
);
   localparam pbar_pkg::pbar_per_t per_rst = '{
      port_five_data_latch: `PBAR_PDAT_RST, port_five_direction: `PBAR_PDIR_RST,
      reload: `PBAR_TMR_RST, count: `PBAR_TMR_RST, wide: `PBAR_WIDE_RST};
   pbar_pkg::pbar_per_t s_q;
   pbar_pkg::pbar_per_t s_d;
   logic [7:0]          mix;

   // ==========================================================
   // next state and read mux
   always_comb begin
      s_d = s_q;
      s_d.count = (s_q.count == 8'hff) ? s_q.reload : s_q.count + 8'h01;
      mix = (s_q.port_five_direction & s_q.port_five_data_latch) |
            (~s_q.port_five_direction & port_five_pin_in);
      if (acc_wr) begin
         if (acc_addr == `PBAR_PDAT_ADDR) s_d.port_five_data_latch = acc_wdata[7:0];
         else if (acc_addr == `PBAR_PDIR_ADDR) s_d.port_five_direction = acc_wdata[7:0];
         else if (acc_addr == `PBAR_TMR_ADDR) s_d.reload = acc_wdata[7:0];
         else if (acc_addr[15:1] == 15'(`PBAR_WIDE_ADDR >> 1)) s_d.wide = acc_wdata;
      end
      if (acc_addr == `PBAR_PDAT_ADDR) acc_rdata = {8'h00, mix};
      else if (acc_addr == `PBAR_PDIR_ADDR) acc_rdata = {8'h00, `PBAR_DIR_READ};
      else if (acc_addr == `PBAR_TMR_ADDR) acc_rdata = {8'h00, s_q.count};
      else if (acc_addr[15:1] == 15'(`PBAR_WIDE_ADDR >> 1)) acc_rdata = s_q.wide;
      else acc_rdata = `PBAR_UNMAP_READ;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) s_q <= per_rst;
      else s_q <= s_d;
   end

   // direction 1 drives the latch level onto the pin
   assign port_five_pin_out = s_q.port_five_data_latch;
   assign port_five_pin_oe  = s_q.port_five_direction;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   port_mix_a: assert property (acc_addr == `PBAR_PDAT_ADDR |-> acc_rdata[7:0] ==
      ((port_five_pin_oe & port_five_pin_out) | (~port_five_pin_oe & port_five_pin_in)))
      else $error("port read does not mix pins and latch");
   dir_ones_a: assert property (acc_addr == `PBAR_PDIR_ADDR |-> acc_rdata == 16'h00ff)
      else $error("direction read not all ones");
   reload_only_a: assert property (acc_wr && acc_addr == `PBAR_TMR_ADDR &&
      s_q.count != 8'hff |=> s_q.reload == $past(acc_wdata[7:0]) &&
      s_q.count == $past(s_q.count) + 8'h01)
      else $error("counter write disturbed running count");
endmodule // pbar_periph

/* File: src/pbar_bus_path.sv */
// pbar_bus_path.sv: cpu access path to on-chip memory and peripheral registers
// assumes: one request at a time; pin inputs synchronous to clk; halt, wake, exc are pulses
`timescale 1ns/1ns
`include "pbar_defs.svh"
module pbar_bus_path (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                req_valid,
   output logic                     req_ready,
   input  wire pbar_pkg::pbar_op_t  req_op,
   input  wire logic [15:0]         req_addr,
   input  wire logic                req_word,
   input  wire logic [15:0]         req_wdata,
   input  wire logic [2:0]          req_bit,
   input  wire logic                req_bit_val,
   input  wire logic [15:0]         block_move_source_ptr,
   input  wire logic [15:0]         block_move_dest_ptr,
   input  wire logic [7:0]          block_move_count_reg,
   output logic                     rsp_done,
   output logic                     rsp_err,
   output logic [15:0]              rsp_rdata,
   input  wire logic                sub_sel,
   input  wire logic                halt_req,
   input  wire logic [1:0]          halt_kind,
   input  wire logic                wake,
   input  wire logic                exc_req,
   output pbar_pkg::pbar_cpu_t      cpu_state,
   input  wire logic [7:0]          port_five_pin_in,
   output logic      [7:0]          port_five_pin_out,
   output logic      [7:0]          port_five_pin_oe
);
   localparam pbar_pkg::pbar_core_t core_rst = '{fsm: pbar_pkg::fsm_idle,
      cpu: pbar_pkg::cpu_reset, op: pbar_pkg::op_read, default: '0};
   pbar_pkg::pbar_core_t s_q;
   pbar_pkg::pbar_core_t s_d;
   logic [7:0]           mem_q [256];
   logic [15:0]          cur_a;
   logic [15:0]          bus_wd;
   logic [15:0]          rv;
   logic [15:0]          per_rdata;
   logic [7:0]           bo;
   logic                 tick;
   logic                 bus_end;
   logic                 word_cyc;
   logic                 is_bit;
   logic                 start;
   logic                 mem_we;
   logic                 per_wr;

   // ==========================================================
   // address decode
   function automatic logic is_mem(input logic [15:0] a);
      is_mem = (a >= `PBAR_RAM_BASE) && (a <= `PBAR_RAM_TOP);
   endfunction
   function automatic logic is_wide(input logic [15:0] a);
      is_wide = a[15:1] == 15'(`PBAR_WIDE_ADDR >> 1);
   endfunction
   function automatic logic is_per(input logic [15:0] a);
      is_per = is_wide(a) || a == `PBAR_TMR_ADDR || a == `PBAR_PDAT_ADDR ||
               a == `PBAR_PDIR_ADDR;
   endfunction
   // state count is fixed per register
   function automatic logic [1:0] acc_states(input logic [15:0] a);
      acc_states = (is_wide(a) || a == `PBAR_TMR_ADDR) ? `PBAR_THREE_STATE
                                                       : `PBAR_TWO_STATE;
   endfunction
   function automatic logic [7:0] bit_mod(input pbar_pkg::pbar_op_t op, input logic [7:0] b,
                                          input logic [2:0] k, input logic v);
      logic [7:0] m;
      m = 8'h01 << k;
      case (op)
         pbar_pkg::bit_set_instruction: bit_mod = b | m;
         pbar_pkg::bit_clear_instruction: bit_mod = b & ~m;
         pbar_pkg::bit_invert_instruction: bit_mod = b ^ m;
         pbar_pkg::bit_store_instruction: bit_mod = v ? (b | m) : (b & ~m);
         pbar_pkg::bit_inverted_store_instruction: bit_mod = v ? (b & ~m) : (b | m);
         default: bit_mod = b;
      endcase
   endfunction

   // ==========================================================
   // datapath
   always_comb begin
      cur_a = s_q.addr + {15'h0000, s_q.half};
      word_cyc = s_q.word && (is_mem(cur_a) || is_wide(cur_a));
      bo = (s_q.word && !s_q.half) ? s_q.wd[15:8] : s_q.wd[7:0];
      bus_wd = word_cyc ? s_q.wd : {8'h00, bo};
      // subclock states come from the divider enable
      tick = (s_q.cpu == pbar_pkg::cpu_active) ||
             (s_q.cpu == pbar_pkg::cpu_subactive && s_q.div == 4'h0);
      bus_end = s_q.fsm == pbar_pkg::fsm_bus && tick &&
                s_q.st == acc_states(cur_a) - 2'h1;
      is_bit = s_q.op != pbar_pkg::op_read && s_q.op != pbar_pkg::op_write &&
               s_q.op != pbar_pkg::block_move_instruction;
      mem_we = bus_end && s_q.wr && is_mem(cur_a);
      per_wr = bus_end && s_q.wr && is_per(cur_a);
      if (is_mem(cur_a)) begin
         rv = word_cyc ? {mem_q[{cur_a[7:1], 1'b0}], mem_q[{cur_a[7:1], 1'b1}]}
                       : {8'h00, mem_q[cur_a[7:0]]};
      end else if (is_per(cur_a)) begin
         rv = per_rdata;
      end else begin
         rv = `PBAR_UNMAP_READ;
      end
      req_ready = s_q.fsm == pbar_pkg::fsm_idle && !halt_req && !exc_req &&
                  (s_q.cpu == pbar_pkg::cpu_active || s_q.cpu == pbar_pkg::cpu_subactive);
      start = req_valid && req_ready;
   end

   // ==========================================================
   // sequencer
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.div = (s_q.cpu != pbar_pkg::cpu_subactive || s_q.div == 4'h0) ? `PBAR_SUB_DIV
                                                                          : s_q.div - 4'h1;
      case (s_q.fsm)
         pbar_pkg::fsm_idle: begin
            if (start) begin
               s_d.op = req_op;
               s_d.addr = req_addr;
               s_d.wd = req_wdata;
               s_d.word = req_word &&
                          (req_op == pbar_pkg::op_read || req_op == pbar_pkg::op_write);
               s_d.wr = req_op == pbar_pkg::op_write;
               s_d.half = 1'b0;
               s_d.st = 2'h0;
               s_d.rd = 16'h0000;
               s_d.bitn = req_bit;
               s_d.bitv = req_bit_val;
               s_d.src = block_move_source_ptr;
               s_d.dst = block_move_dest_ptr;
               s_d.cnt = block_move_count_reg;
               s_d.err = 1'b0;
               s_d.fsm = pbar_pkg::fsm_bus;
               if (req_op == pbar_pkg::block_move_instruction) begin
                  s_d.addr = block_move_source_ptr;
                  if (block_move_count_reg == 8'h00) begin
                     s_d.fsm = pbar_pkg::fsm_idle;
                     s_d.done = 1'b1;
                  end
               end else if (!s_d.word && is_wide(req_addr)) begin
                  s_d.fsm = pbar_pkg::fsm_idle;
                  s_d.done = 1'b1;
                  s_d.err = 1'b1;
               end
            end
         end
         pbar_pkg::fsm_modify: begin
            s_d.wd = {8'h00, bit_mod(s_q.op, s_q.rd[7:0], s_q.bitn, s_q.bitv)};
            s_d.wr = 1'b1;
            s_d.fsm = pbar_pkg::fsm_bus;
         end
         pbar_pkg::fsm_bus: begin
            if (tick && !bus_end) s_d.st = s_q.st + 2'h1;
            if (bus_end) begin
               s_d.st = 2'h0;
               if (!s_q.wr) begin
                  if (word_cyc) s_d.rd = rv;
                  else if (s_q.word && !s_q.half) s_d.rd[15:8] = rv[7:0];
                  else if (s_q.word) s_d.rd[7:0] = rv[7:0];
                  else s_d.rd = {8'h00, rv[7:0]};
               end
               case (s_q.op)
                  pbar_pkg::op_read, pbar_pkg::op_write: begin
                     if (s_q.word && !word_cyc && !s_q.half) begin
                        s_d.half = 1'b1;
                     end else begin
                        s_d.fsm = pbar_pkg::fsm_idle;
                        s_d.done = 1'b1;
                     end
                  end
                  pbar_pkg::block_move_instruction: begin
                     if (!s_q.wr) begin
                        s_d.wd = {8'h00, rv[7:0]};
                        s_d.wr = 1'b1;
                        s_d.addr = s_q.dst;
                     end else begin
                        s_d.src = s_q.src + 16'h0001;
                        s_d.dst = s_q.dst + 16'h0001;
                        s_d.cnt = s_q.cnt - 8'h01;
                        s_d.addr = s_q.src + 16'h0001;
                        s_d.wr = 1'b0;
                        if (s_q.cnt == 8'h01) begin
                           s_d.fsm = pbar_pkg::fsm_idle;
                           s_d.done = 1'b1;
                        end
                     end
                  end
                  default: begin
                     if (!s_q.wr) begin
                        s_d.fsm = pbar_pkg::fsm_modify;
                     end else begin
                        s_d.fsm = pbar_pkg::fsm_idle;
                        s_d.done = 1'b1;
                     end
                  end
               endcase
            end
         end
         default: s_d.fsm = pbar_pkg::fsm_idle;
      endcase
      // processor operating state, changed only between accesses
      case (s_q.cpu)
         pbar_pkg::cpu_reset: s_d.cpu = pbar_pkg::cpu_exception;
         pbar_pkg::cpu_exception: begin
            s_d.cpu = sub_sel ? pbar_pkg::cpu_subactive : pbar_pkg::cpu_active;
         end
         pbar_pkg::cpu_active, pbar_pkg::cpu_subactive: begin
            if (s_q.fsm == pbar_pkg::fsm_idle) begin
               if (exc_req) s_d.cpu = pbar_pkg::cpu_exception;
               else if (halt_req && halt_kind == 2'h0) s_d.cpu = pbar_pkg::cpu_sleep;
               else if (halt_req && halt_kind == 2'h1) s_d.cpu = pbar_pkg::cpu_standby;
               else if (halt_req) s_d.cpu = pbar_pkg::cpu_subsleep;
               else if (!start) s_d.cpu = sub_sel ? pbar_pkg::cpu_subactive : pbar_pkg::cpu_active;
            end
         end
         pbar_pkg::cpu_sleep, pbar_pkg::cpu_standby, pbar_pkg::cpu_subsleep: begin
            if (wake) s_d.cpu = pbar_pkg::cpu_exception;
         end
         default: s_d.cpu = pbar_pkg::cpu_reset;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) s_q <= core_rst;
      else s_q <= s_d;
   end

   // on-chip memory, big-endian words
   always_ff @(posedge clk) begin
      if (mem_we && word_cyc) begin
         mem_q[{cur_a[7:1], 1'b0}] <= bus_wd[15:8];
         mem_q[{cur_a[7:1], 1'b1}] <= bus_wd[7:0];
      end else if (mem_we) begin
         mem_q[cur_a[7:0]] <= bus_wd[7:0];
      end
   end

   pbar_periph u_periph (
      .clk               (clk),
      .rst_b             (rst_b),
      .acc_addr          (cur_a),
      .acc_wdata         (bus_wd),
      .acc_wr            (per_wr),
      .acc_rdata         (per_rdata),
      .port_five_pin_in  (port_five_pin_in),
      .port_five_pin_out (port_five_pin_out),
      .port_five_pin_oe  (port_five_pin_oe)
   );

   assign rsp_done  = s_q.done;
   assign rsp_err   = s_q.err;
   assign rsp_rdata = s_q.rd;
   assign cpu_state = s_q.cpu;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic [1:0] tk_q;
   logic [1:0] ends_q;
   logic [7:0] moved_q;
   logic [7:0] mv_cnt_q;
   always_ff @(posedge clk) begin
      tk_q <= (!rst_b || s_q.fsm != pbar_pkg::fsm_bus || bus_end) ? 2'h0 : tk_q + 2'(tick);
      ends_q <= (!rst_b || start) ? 2'h0 : ends_q + 2'(bus_end);
      moved_q <= (!rst_b || start) ? 8'h00 : moved_q + 8'(bus_end && s_q.wr &&
                 s_q.op == pbar_pkg::block_move_instruction);
      if (start) mv_cnt_q <= block_move_count_reg;
   end

   sequence rmw_rd_s;
      bus_end && !s_q.wr && is_bit;
   endsequence
   sequence rmw_wr_s;
      s_q.fsm == pbar_pkg::fsm_modify ##1 s_q.fsm == pbar_pkg::fsm_bus && s_q.wr &&
      cur_a == s_q.addr;
   endsequence

   cyc_len_a: assert property (bus_end |-> tk_q == 2'h1 || tk_q == 2'h2)
      else $error("bus cycle not two or three states");
   mem_timing_a: assert property (bus_end && (is_mem(cur_a) || cur_a == `PBAR_PDAT_ADDR)
      |-> tk_q == 2'h1) else $error("two-state cycle length wrong");
   three_state_a: assert property (bus_end && cur_a == `PBAR_TMR_ADDR |-> tk_q == 2'h2)
      else $error("three-state cycle length wrong");
   wide_byte_a: assert property (start && !req_word && is_wide(req_addr) &&
      req_op != pbar_pkg::block_move_instruction |=> rsp_done && rsp_err && ends_q == 2'h0)
      else $error("byte access to wide register not refused");
   narrow_word_a: assert property (rsp_done && s_q.word && !is_mem(s_q.addr) &&
      !is_wide(s_q.addr) |-> ends_q == 2'h2) else $error("narrow word not split in two");
   rmw_seq_a: assert property (rmw_rd_s |=> rmw_wr_s)
      else $error("bit write-back missing or misplaced");
   rmw_bit_a: assert property (bus_end && s_q.wr && is_bit |->
      ((bo ^ s_q.rd[7:0]) & ~(8'h01 << s_q.bitn)) == 8'h00)
      else $error("bit instruction changed other bits");
   move_count_a: assert property (rsp_done && s_q.op == pbar_pkg::block_move_instruction
      |-> moved_q == mv_cnt_q) else $error("block move byte count wrong");
   cpu_boot_a: assert property ($rose(rst_b) |-> s_q.cpu == pbar_pkg::cpu_reset ##1
      s_q.cpu == pbar_pkg::cpu_exception) else $error("reset state sequence wrong");
endmodule // pbar_bus_path

/* File: dv/pbar_pin_model.sv */
// pbar_pin_model.sv: model of the port five pins outside the block
// assumes: the outside world drives ext_level on every pin the block does not drive
`timescale 1ns/1ns
module pbar_pin_model (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_level,
   output logic      [7:0] pin_level
);
   // driven pins show the latch, undriven pins show the outside level
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pbar_pin_model

/* File: dv/pbar_bus_path_tb.sv */
// pbar_bus_path_tb.sv: self-checking bench of the peripheral bus access path
// assumes: pbar_pkg compiled first, pin model in dv/
`timescale 1ns/1ns
`include "pbar_defs.svh"
module pbar_bus_path_tb;
   logic clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_word = 1'b0, req_bit_val = 1'b0;
   logic sub_sel = 1'b0, halt_req = 1'b0, wake = 1'b0, exc_req = 1'b0;
   logic req_ready, rsp_done, rsp_err;
   logic [1:0] halt_kind = 2'h0;
   logic [2:0] req_bit = 3'h0;
   logic [7:0] mv_cnt = 8'h00, pin_in, pin_out, pin_oe, ext = 8'h40, e;
   logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, mv_src = 16'h0, mv_dst = 16'h0;
   logic [15:0] rsp_rdata, r;
   logic [31:0] seed = 32'h547c7119;
   pbar_pkg::pbar_op_t req_op = pbar_pkg::op_read;
   pbar_pkg::pbar_cpu_t cpu_state;
   int n_errors = 0, check_count = 0, cyc = 0;
   pbar_bus_path dut (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_addr(req_addr), .req_word(req_word), .req_wdata(req_wdata),
      .req_bit(req_bit), .req_bit_val(req_bit_val), .block_move_source_ptr(mv_src),
      .block_move_dest_ptr(mv_dst), .block_move_count_reg(mv_cnt), .rsp_done(rsp_done),
      .rsp_err(rsp_err), .rsp_rdata(rsp_rdata), .sub_sel(sub_sel), .halt_req(halt_req),
      .halt_kind(halt_kind), .wake(wake), .exc_req(exc_req), .cpu_state(cpu_state),
      .port_five_pin_in(pin_in), .port_five_pin_out(pin_out), .port_five_pin_oe(pin_oe));
   pbar_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_level(pin_in));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
      check_count++;
      if (s !== x) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask
   // one request, held until taken; lat 0 skips the latency check
   task automatic acc(input pbar_pkg::pbar_op_t op, input logic [15:0] a, input logic w,
                      input logic [15:0] wd, input int lat);
      int n;
      req_op = op;
      req_addr = a;
      req_word = w;
      req_wdata = wd;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      n = 1;
      while (rsp_done !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (lat > 0) chk("latency", n[15:0], lat[15:0]);
      // valid stays low one cycle, so back-to-back calls never retoggle it in one step
      @(negedge clk);
   endtask
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (9) @(negedge clk);
      chk("cpu_state", {9'h0, cpu_state}, 16'h0001);
      chk("pins", {pin_out, pin_oe}, 16'h0000);
      @(negedge clk);
      rst_b = 1'b1;
      // ram word then big-endian byte
      seed = lfsr(seed);
      acc(pbar_pkg::op_write, 16'hfe10, 1'b1, seed[15:0], 3);
      acc(pbar_pkg::op_read, 16'hfe10, 1'b1, 16'h0, 3);
      chk("ram word", rsp_rdata, seed[15:0]);
      acc(pbar_pkg::op_read, 16'hfe11, 1'b0, 16'h0, 3);
      chk("ram byte", rsp_rdata, {8'h00, seed[7:0]});
      // bit ops on ram, expected from a byte model
      for (int k = 2; k < 7; k++) begin
         seed = lfsr(seed);
         r = {8'h00, seed[7:0]};
         req_bit = seed[10:8];
         req_bit_val = seed[11];
         e = r[7:0];
         case (k)
            2: e[req_bit] = 1'b1;
            3: e[req_bit] = 1'b0;
            4: e[req_bit] = ~e[req_bit];
            5: e[req_bit] = req_bit_val;
            default: e[req_bit] = ~req_bit_val;
         endcase
         acc(pbar_pkg::op_write, 16'hfe30, 1'b0, r, 3);
         acc(pbar_pkg::pbar_op_t'(k[2:0]), 16'hfe30, 1'b0, 16'h0, 6);
         acc(pbar_pkg::op_read, 16'hfe30, 1'b0, 16'h0, 3);
         chk("bit op", rsp_rdata, {8'h00, e});
      end
      // block move of three bytes
      for (int i = 0; i < 3; i++) begin
         acc(pbar_pkg::op_write, 16'hfe20 + i[15:0], 1'b0, 16'h11 * i[15:0], 3);
      end
      mv_src = 16'hfe20;
      mv_dst = 16'hfe40;
      mv_cnt = 8'h03;
      acc(pbar_pkg::block_move_instruction, 16'h0, 1'b0, 16'h0, 13);
      for (int i = 0; i < 3; i++) begin
         acc(pbar_pkg::op_read, 16'hfe40 + i[15:0], 1'b0, 16'h0, 3);
         chk("moved", rsp_rdata, 16'h11 * i[15:0]);
      end
      // wide register: word only, three states
      acc(pbar_pkg::op_write, 16'hffa0, 1'b1, seed[31:16], 4);
      acc(pbar_pkg::op_write, 16'hffa1, 1'b0, 16'h00aa, 1);
      chk("refused", {15'h0, rsp_err}, 16'h0001);
      acc(pbar_pkg::op_read, 16'hffa0, 1'b1, 16'h0, 4);
      chk("wide", rsp_rdata, seed[31:16]);
      chk("no refusal", {15'h0, rsp_err}, 16'h0000);
      // shared counter address: reads follow the count, a write leaves it running
      acc(pbar_pkg::op_read, 16'hffb0, 1'b0, 16'h0, 4);
      r = rsp_rdata;
      acc(pbar_pkg::op_write, 16'hffb0, 1'b0, 16'h0000, 4);
      acc(pbar_pkg::op_read, 16'hffb0, 1'b0, 16'h0, 4);
      chk("count", rsp_rdata, {8'h00, r[7:0] + 8'h0a});
      // unmapped space
      acc(pbar_pkg::op_write, 16'h1234, 1'b1, 16'h5a5a, 0);
      acc(pbar_pkg::op_read, 16'h1234, 1'b1, 16'h0, 0);
      chk("unmapped", rsp_rdata, `PBAR_UNMAP_READ);
      // port five: direction, mixed read, read-modify-write
      acc(pbar_pkg::op_write, 16'hffe8, 1'b0, 16'h003f, 3);
      chk("oe", {8'h0, pin_oe}, 16'h003f);
      acc(pbar_pkg::op_read, 16'hffe8, 1'b0, 16'h0, 3);
      chk("dir read", rsp_rdata, 16'h00ff);
      acc(pbar_pkg::op_write, 16'hffd8, 1'b0, 16'h0080, 3);
      acc(pbar_pkg::op_read, 16'hffd8, 1'b0, 16'h0, 3);
      chk("port read", rsp_rdata, 16'h0040);
      req_bit = 3'h0;
      acc(pbar_pkg::bit_set_instruction, 16'hffd8, 1'b0, 16'h0, 6);
      chk("latch", {8'h0, pin_out}, 16'h0041);
      chk("pin high", {15'h0, pin_in[0]}, 16'h0001);
      // port byte kept in a ram copy, changed there and written whole
      acc(pbar_pkg::op_write, 16'hfe50, 1'b0, 16'h0080, 3);
      acc(pbar_pkg::op_write, 16'hffd8, 1'b0, 16'h0080, 3);
      acc(pbar_pkg::bit_set_instruction, 16'hfe50, 1'b0, 16'h0, 6);
      acc(pbar_pkg::op_read, 16'hfe50, 1'b0, 16'h0, 3);
      acc(pbar_pkg::op_write, 16'hffd8, 1'b0, rsp_rdata, 3);
      chk("copy latch", {8'h0, pin_out}, 16'h0081);
      acc(pbar_pkg::op_write, 16'hffd8, 1'b1, 16'ha500, 5);
      chk("word latch", {8'h0, pin_out}, 16'h00a5);
      // halt kinds, then subactive
      for (int k = 0; k < 3; k++) begin
         halt_kind = k[1:0]; halt_req = 1'b1;
         @(negedge clk);
         halt_req = 1'b0;
         @(negedge clk);
         chk("halt", {9'h0, cpu_state}, 16'h0010 << k);
         chk("ready", {15'h0, req_ready}, 16'h0000);
         wake = 1'b1;
         @(negedge clk);
         wake = 1'b0;
         acc(pbar_pkg::op_read, 16'hfe40, 1'b0, 16'h0, 0);
      end
      exc_req = 1'b1;
      @(negedge clk);
      exc_req = 1'b0;
      chk("exception", {9'h0, cpu_state}, 16'h0002);
      chk("exc ready", {15'h0, req_ready}, 16'h0000);
      sub_sel = 1'b1;
      @(negedge clk);
      acc(pbar_pkg::op_read, 16'hfe41, 1'b0, 16'h0, 0);
      chk("sub read", rsp_rdata, 16'h0011);
      chk("subactive", {9'h0, cpu_state}, 16'h0008);
      tally_and_finish();
   end
endmodule // pbar_bus_path_tb
